/* File: logic/iwcdp_pkg.sv */
package iwcdp_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses on the Wishbone port.
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFF_MODE       = 8'h9C;
   localparam logic [7:0]  OFF_TARGET     = 8'hA0;
   localparam logic [7:0]  OFF_START      = 8'hA4;
   localparam logic [7:0]  OFF_GO         = 8'hA8;
   localparam logic [7:0]  OFF_END        = 8'hAC;
   localparam logic [7:0]  OFF_DOM_BASE   = 8'hB0;
   localparam logic [7:0]  OFF_DOM_STEP   = 8'h04;
   localparam logic [7:0]  OFF_MASK       = 8'hD0;
   localparam logic [7:0]  OFF_OVERRIDE   = 8'hD4;
   localparam int          DOM_REGS       = 8;

   // ----------------------------------------------------------------
   // Field layout and reset values.
   // ----------------------------------------------------------------
   localparam int          TAG_LSB        = 20;
   localparam int          TAG_W          = 12;
   localparam int          DOM_IDX_LSB    = 4;
   localparam int          DOM_IDX_W      = 4;
   localparam int          DOMAINS        = 16;
   localparam int          DOM_FIELD_W    = 14;
   localparam int          DOM_HI_LSB     = 16;
   localparam int          DOM_LO_LSB     = 0;
   localparam logic [2:0]  MASTER_ABSENT  = 3'h6;
   localparam int          OVR_EN_BIT     = 0;
   localparam int          OVR_RD_BIT     = 1;
   localparam int          OVR_WR_BIT     = 2;
   localparam logic [2:0]  RST_OVERRIDE   = 3'h0;
   localparam logic [TAG_W-1:0] RST_TAG   = 12'h000;
   localparam logic [TAG_W-1:0] RST_MASK  = 12'h000;
   localparam logic [DOM_FIELD_W-1:0] RST_DOM = 14'h0000;
   localparam logic [31:0] RST_WORD       = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Walk cache geometry.
   // ----------------------------------------------------------------
   localparam int          WC_ENTRIES     = 8;
   localparam int          WC_IDX_W       = 3;
   localparam logic [WC_IDX_W-1:0] WC_LAST = 3'h7;

   typedef enum logic {INV_IDLE, INV_SWEEP} iwcdp_inv_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [2:0]  master;
      logic [31:0] vaddr;
      logic [31:0] l2pte;
   } iwcdp_acc_req_s;

   typedef struct packed {
      logic        valid;
      logic        forward;
      logic        blocked;
      logic        write;
      logic [2:0]  master;
      logic [31:0] vaddr;
   } iwcdp_acc_res_s;

   typedef struct packed {
      logic             valid;
      logic [TAG_W-1:0] tag;
   } iwcdp_wc_port_s;

endpackage

/* File: logic/iwcdp_top.sv */
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
// Contract
// - Mode bit picks mask or range matching.
// - Target address keeps only bits 31:20.
// - Range low bound from start register.
// - Range high bound from end register.
// - Go bit starts, clears itself when done.
// - Lookups keep running during invalidation.
// - Fifteen domains in eight registers plus zero.
// - Domain index from PTE bits 7:4.
// - Reset leaves domains 1-15 fully permitted.
// - Override replaces domain controls for all entries.
// - Per domain/master read, write bits; 1 blocks.
// - Odd domain high half, even low half.
// - Master six bits have no effect.
// - Domain zero bits read zero, never block.
// - Domain one bits read/write, reset zero.
// - Bits 31:30 and 15:14 unused.
module iwcdp_top
   import iwcdp_pkg::*;
(
   input  wire logic           CLK,          // System clock, 10 MHz.
   input  wire logic           RESET,        // Synchronous reset, active high.
   input  wire logic           WB_CYC_I,     // Wishbone cycle.
   input  wire logic           WB_STB_I,     // Wishbone strobe.
   input  wire logic           WB_WE_I,      // Wishbone write enable.
   input  wire logic [7:0]     WB_ADR_I,     // Wishbone byte address.
   input  wire logic [3:0]     WB_SEL_I,     // Wishbone byte selects.
   input  wire logic [31:0]    WB_DAT_I,     // Wishbone write data.
   output logic      [31:0]    WB_DAT_O,     // Wishbone read data.
   output logic                WB_ACK_O,     // Wishbone acknowledge.
   input  iwcdp_acc_req_s      ACC_REQ,      // Translated access to check.
   output iwcdp_acc_res_s      ACC_RES,      // Check result, one cycle later.
   input  iwcdp_wc_port_s      WC_LOOKUP,    // Walk cache lookup.
   input  iwcdp_wc_port_s      WC_FILL,      // Walk cache fill.
   output logic                WC_HIT_VALID, // Lookup answer valid.
   output logic                WC_HIT,       // Lookup hit.
   output logic                INV_BUSY      // Invalidation sweep running.
);

   // ----------------------------------------------------------------
   // Wishbone slave.
   // ----------------------------------------------------------------
   logic                       ack_ff;
   logic                       nxt_ack_ff;
   logic [31:0]                dat_o_ff;
   logic [31:0]                nxt_dat_o_ff;
   logic [31:0]                rd_val;
   logic                       bus_req;
   logic                       bus_wr;

   // Register state.
   logic                       mode_ff;
   logic                       nxt_mode_ff;
   logic [TAG_W-1:0]           target_ff;
   logic [TAG_W-1:0]           nxt_target_ff;
   logic [TAG_W-1:0]           low_ff;
   logic [TAG_W-1:0]           nxt_low_ff;
   logic [TAG_W-1:0]           high_ff;
   logic [TAG_W-1:0]           nxt_high_ff;
   logic [TAG_W-1:0]           mask_ff;
   logic [TAG_W-1:0]           nxt_mask_ff;
   logic [2:0]                 ovr_ff;
   logic [2:0]                 nxt_ovr_ff;
   logic                       go_ff;
   logic                       nxt_go_ff;
   logic [DOM_FIELD_W-1:0]     perm_ff     [DOMAINS];
   logic [DOM_FIELD_W-1:0]     nxt_perm_ff [DOMAINS];
   logic [31:0]                dom_rd      [DOM_REGS];

   // Walk cache and invalidation sweep.
   iwcdp_inv_e                 inv_ff;
   iwcdp_inv_e                 nxt_inv_ff;
   logic [WC_IDX_W-1:0]        sweep_ff;
   logic [WC_IDX_W-1:0]        nxt_sweep_ff;
   logic [WC_ENTRIES-1:0]      wc_valid_ff;
   logic [WC_ENTRIES-1:0]      nxt_wc_valid_ff;
   logic [TAG_W-1:0]           wc_tag_ff     [WC_ENTRIES];
   logic [TAG_W-1:0]           nxt_wc_tag_ff [WC_ENTRIES];
   logic [WC_IDX_W-1:0]        fill_ptr_ff;
   logic [WC_IDX_W-1:0]        nxt_fill_ptr_ff;
   logic                       hit_valid_ff;
   logic                       nxt_hit_valid_ff;
   logic                       hit_ff;
   logic                       nxt_hit_ff;
   logic                       sweep_done;

   // Access check.
   iwcdp_acc_res_s             res_ff;
   iwcdp_acc_res_s             nxt_res_ff;

   function automatic logic [31:0] wb_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] tag_word(input logic [TAG_W-1:0] t);
      return {t, 20'h00000};
   endfunction

   assign bus_req = WB_CYC_I & WB_STB_I;
   // A write lands on the edge where the master sees ack high.
   assign bus_wr  = bus_req & WB_WE_I & ack_ff;

   // ----------------------------------------------------------------
   // Domain register read view.
   // ----------------------------------------------------------------
   genvar gk;
   generate
      for (gk = 0; gk < DOM_REGS; gk++) begin : g_dom_rd
         if (gk == 0) begin : g_zero
            // Domain zero half is hard zero; unused bits 31:30 and 15:14 read zero too.
            assign dom_rd[gk] = {2'b00, perm_ff[2*gk+1], 2'b00, RST_DOM};
         end else begin : g_pair
            assign dom_rd[gk] = {2'b00, perm_ff[2*gk+1], 2'b00, perm_ff[2*gk]};
         end
      end
   endgenerate

   always_comb begin
      rd_val = RST_WORD;
      case (WB_ADR_I)
         OFF_MODE:     rd_val = {31'h0000_0000, mode_ff};
         OFF_TARGET:   rd_val = tag_word(target_ff);
         OFF_START:    rd_val = tag_word(low_ff);
         OFF_GO:       rd_val = {31'h0000_0000, go_ff};
         OFF_END:      rd_val = tag_word(high_ff);
         OFF_MASK:     rd_val = tag_word(mask_ff);
         OFF_OVERRIDE: rd_val = {29'h0000_0000, ovr_ff};
         default: begin
            for (int k = 0; k < DOM_REGS; k++) begin
               if (WB_ADR_I == OFF_DOM_BASE + 8'(k * 4)) begin
                  rd_val = dom_rd[k];
               end
            end
         end
      endcase
      nxt_ack_ff   = bus_req & ~ack_ff;
      nxt_dat_o_ff = (bus_req & ~ack_ff) ? rd_val : dat_o_ff;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ack_ff   <= 1'b0;
         dat_o_ff <= RST_WORD;
      end else begin
         ack_ff   <= nxt_ack_ff;
         dat_o_ff <= nxt_dat_o_ff;
      end
   end

   // ----------------------------------------------------------------
   // Software registers.
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] m;
      m              = RST_WORD;
      nxt_mode_ff    = mode_ff;
      nxt_target_ff  = target_ff;
      nxt_low_ff     = low_ff;
      nxt_high_ff    = high_ff;
      nxt_mask_ff    = mask_ff;
      nxt_ovr_ff     = ovr_ff;
      nxt_go_ff      = go_ff;
      nxt_perm_ff    = perm_ff;
      if (sweep_done) begin
         nxt_go_ff = 1'b0;
      end
      if (bus_wr) begin
         case (WB_ADR_I)
            OFF_MODE: begin
               m           = wb_merge({31'h0000_0000, mode_ff}, WB_DAT_I, WB_SEL_I);
               nxt_mode_ff = m[0];
            end
            OFF_TARGET: begin
               m             = wb_merge(tag_word(target_ff), WB_DAT_I, WB_SEL_I);
               nxt_target_ff = m[31:TAG_LSB];
            end
            OFF_START: begin
               m          = wb_merge(tag_word(low_ff), WB_DAT_I, WB_SEL_I);
               nxt_low_ff = m[31:TAG_LSB];
            end
            OFF_END: begin
               m           = wb_merge(tag_word(high_ff), WB_DAT_I, WB_SEL_I);
               nxt_high_ff = m[31:TAG_LSB];
            end
            OFF_MASK: begin
               m           = wb_merge(tag_word(mask_ff), WB_DAT_I, WB_SEL_I);
               nxt_mask_ff = m[31:TAG_LSB];
            end
            OFF_OVERRIDE: begin
               m          = wb_merge({29'h0000_0000, ovr_ff}, WB_DAT_I, WB_SEL_I);
               nxt_ovr_ff = m[2:0];
            end
            OFF_GO: begin
               // Writing zero has no effect; a one wins over a finishing sweep.
               if (WB_SEL_I[0] && WB_DAT_I[0]) begin
                  nxt_go_ff = 1'b1;
               end
            end
            default: begin
               for (int k = 0; k < DOM_REGS; k++) begin
                  if (WB_ADR_I == OFF_DOM_BASE + 8'(k * 4)) begin
                     m = wb_merge(dom_rd[k], WB_DAT_I, WB_SEL_I);
                     nxt_perm_ff[2*k+1] = m[DOM_HI_LSB +: DOM_FIELD_W];
                     if (k != 0) begin
                        nxt_perm_ff[2*k] = m[DOM_LO_LSB +: DOM_FIELD_W];
                     end
                  end
               end
            end
         endcase
      end
      nxt_perm_ff[0] = RST_DOM;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         mode_ff   <= 1'b0;
         target_ff <= RST_TAG;
         low_ff    <= RST_TAG;
         high_ff   <= RST_TAG;
         mask_ff   <= RST_MASK;
         ovr_ff    <= RST_OVERRIDE;
         go_ff     <= 1'b0;
         for (int d = 0; d < DOMAINS; d++) begin
            perm_ff[d] <= RST_DOM;
         end
      end else begin
         mode_ff   <= nxt_mode_ff;
         target_ff <= nxt_target_ff;
         low_ff    <= nxt_low_ff;
         high_ff   <= nxt_high_ff;
         mask_ff   <= nxt_mask_ff;
         ovr_ff    <= nxt_ovr_ff;
         go_ff     <= nxt_go_ff;
         perm_ff   <= nxt_perm_ff;
      end
   end

   // ----------------------------------------------------------------
   // Walk cache with invalidation sweep.
   // ----------------------------------------------------------------
   // The sweep visits one entry per cycle and never stalls lookups or
   // fills, so a fill racing the sweep may survive; software must not
   // count on either outcome.
   assign sweep_done = (inv_ff == INV_SWEEP) && (sweep_ff == WC_LAST);

   always_comb begin
      logic [TAG_W-1:0] t;
      logic             hit;
      logic             match;
      t                = wc_tag_ff[sweep_ff];
      hit              = 1'b0;
      match            = 1'b0;
      nxt_inv_ff       = inv_ff;
      nxt_sweep_ff     = sweep_ff;
      nxt_wc_valid_ff  = wc_valid_ff;
      nxt_wc_tag_ff    = wc_tag_ff;
      nxt_fill_ptr_ff  = fill_ptr_ff;
      for (int e = 0; e < WC_ENTRIES; e++) begin
         if (wc_valid_ff[e] && wc_tag_ff[e] == WC_LOOKUP.tag) begin
            hit = 1'b1;
         end
      end
      nxt_hit_valid_ff = WC_LOOKUP.valid;
      nxt_hit_ff       = WC_LOOKUP.valid & hit;
      if (mode_ff) begin
         match = (t >= low_ff) && (t <= high_ff);
      end else begin
         match = ((t ^ target_ff) & mask_ff) == RST_MASK;
      end
      case (inv_ff)
         INV_IDLE: begin
            if (go_ff) begin
               nxt_inv_ff   = INV_SWEEP;
               nxt_sweep_ff = '0;
            end
         end
         INV_SWEEP: begin
            if (match) begin
               nxt_wc_valid_ff[sweep_ff] = 1'b0;
            end
            nxt_sweep_ff = sweep_ff + 3'h1;
            if (sweep_done) begin
               nxt_inv_ff = INV_IDLE;
            end
         end
         default: begin
            nxt_inv_ff = INV_IDLE;
         end
      endcase
      // A fill lands after the sweep's clear, so the newer entry stays.
      if (WC_FILL.valid) begin
         nxt_wc_valid_ff[fill_ptr_ff] = 1'b1;
         nxt_wc_tag_ff[fill_ptr_ff]   = WC_FILL.tag;
         nxt_fill_ptr_ff              = fill_ptr_ff + 3'h1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         inv_ff       <= INV_IDLE;
         sweep_ff     <= '0;
         wc_valid_ff  <= '0;
         fill_ptr_ff  <= '0;
         hit_valid_ff <= 1'b0;
         hit_ff       <= 1'b0;
         for (int e = 0; e < WC_ENTRIES; e++) begin
            wc_tag_ff[e] <= RST_TAG;
         end
      end else begin
         inv_ff       <= nxt_inv_ff;
         sweep_ff     <= nxt_sweep_ff;
         wc_valid_ff  <= nxt_wc_valid_ff;
         wc_tag_ff    <= nxt_wc_tag_ff;
         fill_ptr_ff  <= nxt_fill_ptr_ff;
         hit_valid_ff <= nxt_hit_valid_ff;
         hit_ff       <= nxt_hit_ff;
      end
   end

   // ----------------------------------------------------------------
   // Permission check of translated accesses.
   // ----------------------------------------------------------------
   always_comb begin
      logic [DOM_IDX_W-1:0] dom;
      logic [3:0]           bit_rd;
      logic                 rd_blk;
      logic                 wr_blk;
      logic                 blk;
      dom    = ACC_REQ.l2pte[DOM_IDX_LSB +: DOM_IDX_W];
      bit_rd = {ACC_REQ.master, 1'b0};
      rd_blk = 1'b0;
      wr_blk = 1'b0;
      if (ovr_ff[OVR_EN_BIT]) begin
         rd_blk = ovr_ff[OVR_RD_BIT];
         wr_blk = ovr_ff[OVR_WR_BIT];
      end else if (dom != '0 && ACC_REQ.master < MASTER_ABSENT) begin
         rd_blk = perm_ff[dom][bit_rd];
         wr_blk = perm_ff[dom][bit_rd + 4'h1];
      end
      blk                = ACC_REQ.write ? wr_blk : rd_blk;
      nxt_res_ff.valid   = ACC_REQ.valid;
      nxt_res_ff.forward = ACC_REQ.valid & ~blk;
      nxt_res_ff.blocked = ACC_REQ.valid & blk;
      nxt_res_ff.write   = ACC_REQ.write;
      nxt_res_ff.master  = ACC_REQ.master;
      nxt_res_ff.vaddr   = ACC_REQ.vaddr;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         res_ff <= '0;
      end else begin
         res_ff <= nxt_res_ff;
      end
   end

   assign WB_ACK_O     = ack_ff;
   assign WB_DAT_O     = dat_o_ff;
   assign ACC_RES      = res_ff;
   assign WC_HIT_VALID = hit_valid_ff;
   assign WC_HIT       = hit_ff;
   assign INV_BUSY     = (inv_ff == INV_SWEEP);

endmodule

/* File: tb/iwcdp_chk.sv */
`timescale 1ns/1ps
module iwcdp_chk
   import iwcdp_pkg::*;
(
   input  wire logic        CLK,          // Clock.
   input  wire logic        RESET,        // Reset.
   input  wire logic        WB_CYC_I,     // Cycle.
   input  wire logic        WB_STB_I,     // Strobe.
   input  wire logic        WB_WE_I,      // Write.
   input  wire logic [7:0]  WB_ADR_I,     // Address.
   input  wire logic [3:0]  WB_SEL_I,     // Lanes.
   input  wire logic [31:0] WB_DAT_I,     // Write data.
   input  wire logic [31:0] WB_DAT_O,     // Read data.
   input  wire logic        WB_ACK_O,     // Ack.
   input  iwcdp_acc_req_s   ACC_REQ,      // Access.
   input  iwcdp_acc_res_s   ACC_RES,      // Verdict.
   input  iwcdp_wc_port_s   WC_LOOKUP,    // Lookup.
   input  iwcdp_wc_port_s   WC_FILL,      // Fill.
   input  wire logic        WC_HIT_VALID, // Answer.
   input  wire logic        WC_HIT,       // Hit.
   input  wire logic        INV_BUSY      // Sweep.
);
   logic ovr_en_ff;
   logic nxt_ovr_en;
   logic wr_ack;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   // Shadow of the override enable, so domain-zero freedom is only demanded while it is off.
   assign wr_ack = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
   always_comb begin
      nxt_ovr_en = ovr_en_ff;
      if (RESET) begin
         nxt_ovr_en = 1'b0;
      end else if (wr_ack && WB_ADR_I == OFF_OVERRIDE && WB_SEL_I[0]) begin
         nxt_ovr_en = WB_DAT_I[OVR_EN_BIT];
      end
   end
   always_ff @(posedge CLK) begin
      ovr_en_ff <= nxt_ovr_en;
   end

   property p_ack_next;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not acknowledged next cycle");
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("acknowledge longer than one cycle");
   property p_res_next;
      ACC_REQ.valid |=> ACC_RES.valid && (ACC_RES.forward != ACC_RES.blocked)
         && ACC_RES.vaddr == $past(ACC_REQ.vaddr) && ACC_RES.write == $past(ACC_REQ.write);
   endproperty
   a_res_next: assert property (p_res_next)
      else $error("access verdict missing or inconsistent");
   property p_res_quiet;
      !ACC_REQ.valid |=> !ACC_RES.valid && !ACC_RES.forward && !ACC_RES.blocked;
   endproperty
   a_res_quiet: assert property (p_res_quiet)
      else $error("verdict without access");
   property p_dom0_free;
      ACC_REQ.valid && !ovr_en_ff && (ACC_REQ.l2pte[7:4] == 4'h0 || ACC_REQ.master >= MASTER_ABSENT)
         |=> ACC_RES.forward;
   endproperty
   a_dom0_free: assert property (p_dom0_free)
      else $error("unrestricted access was blocked");
   property p_go_busy;
      wr_ack && WB_ADR_I == OFF_GO && WB_SEL_I[0] && WB_DAT_I[0] |-> ##[1:3] INV_BUSY;
   endproperty
   a_go_busy: assert property (p_go_busy)
      else $error("sweep did not start after go");
   property p_sweep_len;
      $rose(INV_BUSY) |-> INV_BUSY [*8];
   endproperty
   a_sweep_len: assert property (p_sweep_len)
      else $error("sweep shorter than the cache");
   property p_lookup_busy;
      WC_LOOKUP.valid && INV_BUSY |=> WC_HIT_VALID;
   endproperty
   a_lookup_busy: assert property (p_lookup_busy)
      else $error("lookup stalled by sweep");
endmodule

bind iwcdp_top iwcdp_chk iwcdp_chk_inst (
   .CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .ACC_REQ(ACC_REQ), .ACC_RES(ACC_RES), .WC_LOOKUP(WC_LOOKUP),
   .WC_FILL(WC_FILL), .WC_HIT_VALID(WC_HIT_VALID), .WC_HIT(WC_HIT), .INV_BUSY(INV_BUSY)
);

/* File: tb/iwcdp_acc_master.sv */
`timescale 1ns/1ps
module iwcdp_acc_master
   import iwcdp_pkg::*;
(
   input  wire logic     clk,     // Clock.
   output iwcdp_acc_req_s acc_req, // Access out.
   input  iwcdp_acc_res_s acc_res  // Verdict in.
);
   initial begin
      acc_req = '0;
   end

   // Accesses go out regardless of any sweep in flight and assume no order against it.
   task automatic issue(input logic wr, input logic [2:0] mst, input logic [3:0] dom,
                        output iwcdp_acc_res_s res);
      @(posedge clk);
      acc_req <= '{valid: 1'b1, write: wr, master: mst, vaddr: {25'h0ACE5A5, mst, dom},
                   l2pte: {20'hC3C3C, 4'h5, dom, 4'hA}};
      @(posedge clk);
      acc_req.valid <= 1'b0;
      // The released address flips so a stale value never passes for a live one.
      acc_req.vaddr <= ~acc_req.vaddr;
      @(posedge clk);
      res = acc_res;
   endtask
endmodule

/* File: tb/iwcdp_top_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module iwcdp_top_test
   import iwcdp_pkg::*;
;
   logic           clk;
   logic           reset;
   logic           wb_cyc;
   logic           wb_stb;
   logic           wb_we;
   logic [7:0]     wb_adr;
   logic [3:0]     wb_sel;
   logic [31:0]    wb_wdat;
   logic [31:0]    wb_rdat;
   logic           wb_ack;
   iwcdp_acc_req_s acc_req;
   iwcdp_acc_res_s acc_res;
   iwcdp_wc_port_s wc_lookup;
   iwcdp_wc_port_s wc_fill;
   logic           wc_hit_valid;
   logic           wc_hit;
   logic           inv_busy;
   int             num_errors;
   int             checks;

   iwcdp_top iwcdp_top_inst (
      .CLK(clk), .RESET(reset), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
      .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat),
      .WB_ACK_O(wb_ack), .ACC_REQ(acc_req), .ACC_RES(acc_res), .WC_LOOKUP(wc_lookup),
      .WC_FILL(wc_fill), .WC_HIT_VALID(wc_hit_valid), .WC_HIT(wc_hit), .INV_BUSY(inv_busy)
   );
   iwcdp_acc_master iwcdp_acc_master_inst (.clk(clk), .acc_req(acc_req), .acc_res(acc_res));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus and port helpers.
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_wdat <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_wdat <= ~wd;
   endtask

   task automatic wb_wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] rd;
      wb_xfer(1'b1, adr, 4'hF, d, rd);
   endtask

   task automatic wb_rd(input string nm, input logic [7:0] adr, input logic [31:0] ex);
      logic [31:0] rd;
      wb_xfer(1'b0, adr, 4'hF, 32'h0, rd);
      `CHK(nm, ex, rd)
   endtask

   task automatic fill(input logic [11:0] tag);
      @(posedge clk);
      wc_fill <= '{valid: 1'b1, tag: tag};
      @(posedge clk);
      wc_fill <= '{valid: 1'b0, tag: ~tag};
   endtask

   task automatic lookup(input logic [11:0] tag, input logic hit);
      @(posedge clk);
      wc_lookup <= '{valid: 1'b1, tag: tag};
      @(posedge clk);
      wc_lookup <= '{valid: 1'b0, tag: ~tag};
      @(posedge clk);
      `CHK("lookup", {1'b1, hit}, {wc_hit_valid, wc_hit})
   endtask

   task automatic acc(input logic wr, input logic [2:0] mst, input logic [3:0] dom, input logic blk);
      iwcdp_acc_res_s res;
      iwcdp_acc_master_inst.issue(wr, mst, dom, res);
      `CHK("verdict", {1'b1, ~blk, blk}, {res.valid, res.forward, res.blocked})
      `CHK("verdict id", {wr, mst}, {res.write, res.master})
   endtask

   function automatic logic [31:0] dom_bit(int dom, int mst, int wr);
      return 32'h1 << ((dom % 2 ? DOM_HI_LSB : DOM_LO_LSB) + 2 * mst + wr);
   endfunction

   // Starts a sweep, probes the cache while it runs, then polls go down.
   task automatic inv_run;
      logic [31:0] rd;
      int n;
      n = 0;
      wb_wr(OFF_GO, 32'h1);
      lookup(12'h100, 1'b1);
      do begin
         wb_xfer(1'b0, OFF_GO, 4'hF, 32'h0, rd);
         n++;
      end while (rd[0] !== 1'b0 && n < 30);
      `CHK("go", RST_WORD, rd)
      if (n >= 30) begin
         end_of_test();
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic test_reset;
      logic [7:0] a;
      for (a = OFF_MODE; a <= OFF_OVERRIDE; a += 8'h04) begin
         wb_rd("reset value", a, RST_WORD);
      end
      $display("test reset finished");
   endtask

   task automatic test_regs;
      logic [7:0]  adr [8];
      logic [31:0] ex [8];
      logic [31:0] rd;
      adr = '{OFF_MODE, OFF_TARGET, OFF_START, OFF_END, OFF_DOM_BASE, OFF_MASK, OFF_OVERRIDE, 8'hF0};
      ex = '{32'h1, 32'hFFF0_0000, 32'hFFF0_0000, 32'hFFF0_0000, 32'h3FFF_0000, 32'hFFF0_0000, 32'h7, 32'h0};
      for (int i = 0; i < 8; i++) begin
         wb_wr(adr[i], 32'hFFFF_FFFF);
         wb_rd("register", adr[i], ex[i]);
         wb_wr(adr[i], RST_WORD);
      end
      wb_xfer(1'b1, OFF_DOM_BASE + OFF_DOM_STEP, 4'h4, 32'hFFFF_FFFF, rd);
      wb_rd("lane", OFF_DOM_BASE + OFF_DOM_STEP, 32'h00FF_0000);
      wb_wr(OFF_DOM_BASE + OFF_DOM_STEP, RST_WORD);
      $display("test regs finished");
   endtask

   task automatic test_perm;
      wb_wr(OFF_DOM_BASE, dom_bit(1, 2, 0) | dom_bit(1, 6, 0) | dom_bit(1, 6, 1));
      wb_wr(OFF_DOM_BASE + 8'h04, dom_bit(2, 0, 0));
      wb_wr(OFF_DOM_BASE + 8'h1C, dom_bit(15, 5, 1));
      acc(1'b0, 3'h2, 4'h1, 1'b1);
      acc(1'b1, 3'h2, 4'h1, 1'b0);
      acc(1'b0, 3'h6, 4'h1, 1'b0);
      acc(1'b1, 3'h6, 4'h1, 1'b0);
      acc(1'b0, 3'h2, 4'h0, 1'b0);
      acc(1'b0, 3'h0, 4'h2, 1'b1);
      acc(1'b0, 3'h0, 4'h3, 1'b0);
      acc(1'b1, 3'h5, 4'hF, 1'b1);
      acc(1'b0, 3'h5, 4'hF, 1'b0);
      wb_wr(OFF_OVERRIDE, 32'h1 << OVR_EN_BIT | 32'h1 << OVR_WR_BIT);
      acc(1'b1, 3'h2, 4'h0, 1'b1);
      acc(1'b0, 3'h2, 4'h1, 1'b0);
      wb_wr(OFF_OVERRIDE, 32'h1 << OVR_EN_BIT | 32'h1 << OVR_RD_BIT);
      acc(1'b0, 3'h0, 4'h3, 1'b1);
      acc(1'b1, 3'h0, 4'h3, 1'b0);
      wb_wr(OFF_OVERRIDE, RST_WORD);
      acc(1'b0, 3'h2, 4'h1, 1'b1);
      $display("test perm finished");
   endtask

   task automatic test_inval;
      logic [11:0] tags [4];
      tags = '{12'h100, 12'h101, 12'h105, 12'h10A};
      for (int i = 0; i < 4; i++) begin
         fill(tags[i]);
      end
      lookup(12'h101, 1'b1);
      wb_wr(OFF_START, {12'h101, 20'h0});
      wb_wr(OFF_END, {12'h105, 20'h0});
      wb_wr(OFF_MODE, 32'h1);
      inv_run();
      lookup(12'h101, 1'b0);
      lookup(12'h105, 1'b0);
      lookup(12'h10A, 1'b1);
      wb_wr(OFF_MODE, RST_WORD);
      wb_wr(OFF_TARGET, {12'h10A, 20'hFFFFF});
      wb_wr(OFF_MASK, {12'hFFF, 20'h0});
      inv_run();
      lookup(12'h10A, 1'b0);
      $display("test inval finished");
   endtask

   initial begin
      reset = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_wdat = 32'h0;
      wc_lookup = '0;
      wc_fill = '0;
      num_errors = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      test_reset();
      test_regs();
      test_perm();
      test_inval();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
